// >>> src/lowpower_pkg.sv
// constants shared by the break and low-power controller
// assumes a 250 MHz system clock and an AXI4-Lite register bus
package lowpower_pkg;
    // register indices; each register is one word at four times its index
    localparam logic [15:0] PEND_HIGH_OFFSET = 16'hfe05;
    localparam logic [15:0] BREAK_STATUS_OFFSET = 16'hfe00;
    localparam logic [15:0] FLAG_CONTROL_OFFSET = 16'hfe04;
    localparam logic [15:0] MODE_CONFIG_OFFSET = 16'hfe08;
    // field positions
    localparam int BREAK_EXITED_BIT = 1;
    localparam int FLAG_CLEAR_EN_BIT = 7;
    localparam int WATCHDOG_DIS_BIT = 0;
    localparam int SHORT_REC_BIT = 1;
    // reset values
    localparam logic [7:0] PEND_HIGH_RESET = 8'h00;
    localparam logic [1:0] MODE_CONFIG_RESET = 2'h0;
    // recovery counts in divided-oscillator cycles
    localparam logic [12:0] LONG_RECOVERY = 13'h1000;
    localparam logic [12:0] SHORT_RECOVERY = 13'h0800;
    // oscillator divider, in system clocks per divided-oscillator cycle
    localparam logic [3:0] OSC_DIV_COUNT = 4'h4;
    // software-trap vector location
    localparam logic [15:0] TRAP_VECTOR = 16'hfffc;
    // power sequencer states, gray along run-stop-recover-stack-run
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_WAIT = 3'h4,
        ST_STOP = 3'h1,
        ST_RECOVER = 3'h3,
        ST_STACK = 3'h2
    } power_state_type;
endpackage : lowpower_pkg

// >>> src/flag_guard.sv
// clear-protection for peripheral status flags during break
// assumes clear requests and flag sets arrive as one-cycle pulses from logic on clk
`timescale 1ns/1ns
`default_nettype none
module flag_guard (
    input wire logic clk,
    input wire logic rst,
    input wire logic inBreak,
    input wire logic clearEnable,
    input wire logic [7:0] flagSet,
    input wire logic [7:0] stepOne,
    input wire logic [7:0] stepTwo,
    output logic [7:0] flags
);
    logic [7:0] armed;
    logic [7:0] allowClear;

    // a clear is allowed outside break or with the enable set
    assign allowClear = (!inBreak || clearEnable) ? 8'hff : 8'h00;

    // first step of a two-step clear arms; second step clears only when allowed
    always_ff @(posedge clk) begin
        if (rst) begin
            armed <= 8'h00;
        end else begin
            armed <= (armed | stepOne) & ~(stepTwo & allowClear);
        end
    end

    // set wins over clear; a cleared flag stays clear after break
    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= 8'h00;
        end else begin
            flags <= (flags & ~(stepTwo & armed & allowClear)) | flagSet;
        end
    end
endmodule : flag_guard
`default_nettype wire

// >>> src/lowpower_break_ctrl.sv
// reserved file: holds no logic
// the sequencer top is lowpower_main, with flag_guard beneath it

// >>> src/lowpower_main.sv
// break and low-power sequencer with AXI4-Lite registers
// assumes core, peripherals and break unit on clk; reset pin is asynchronous
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module lowpower_main (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic waitExec,
    input wire logic stopExec,
    input wire logic [7:0] irqPending,
    input wire logic anyIrq,
    input wire logic breakRequest,
    input wire logic resetPin,
    input wire logic internalReset,
    input wire logic [7:0] flagSet,
    input wire logic [7:0] clearStepOne,
    input wire logic [7:0] clearStepTwo,
    output logic systemReset,
    output logic maskClear,
    output logic forceVector,
    output logic [15:0] vectorAddress,
    output logic inBreak,
    output logic coreClockEnable,
    output logic peripheralClockEnable,
    output logic oscClockEnable,
    output logic watchdogRun,
    output logic stackStart,
    output logic breakExitedOut,
    output logic [7:0] protectedFlags
);
    lowpower_pkg::power_state_type state;
    lowpower_pkg::power_state_type next_state;
    logic [2:0] pinSync;
    logic pinLevel;
    logic anyReset;
    logic [7:0] pendingSourcesHigh;
    logic breakExitedLowpower;
    logic breakFlagClearEnable;
    logic watchdogDisable;
    logic shortStopRecovery;
    logic [3:0] divCount;
    logic divTick;
    logic [12:0] recoverCount;
    logic [12:0] recoverTarget;
    logic breakSeen;
    logic wakeEvent;
    logic lowpowerBreak;
    logic [15:0] wrAddr;
    logic haveAw;
    logic haveW;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic doWrite;

    // offsets are register indices; the byte address is four times the index
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] offset);
        hit = (addr[15:2] == offset[13:0]);
    endfunction : hit

    // reset pin through three flops; level changes once last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            pinSync <= 3'h0;
            pinLevel <= 1'b0;
        end else begin
            pinSync <= {pinSync[1:0], resetPin};
            if (pinSync[2] == pinSync[1]) begin
                pinLevel <= pinSync[2];
            end
        end
    end

    // every reset source alike, no arbitration
    assign anyReset = rst || pinLevel || internalReset;

    always_ff @(posedge clk) begin
        if (rst) begin
            systemReset <= 1'b1;
        end else begin
            systemReset <= pinLevel || internalReset;
        end
    end

    // high pending sources snapshot
    always_ff @(posedge clk) begin
        if (anyReset) begin
            pendingSourcesHigh <= lowpower_pkg::PEND_HIGH_RESET;
        end else begin
            pendingSourcesHigh <= irqPending;
        end
    end

    // divided oscillator tick, stopped while oscillator is off
    always_ff @(posedge clk) begin
        if (anyReset || state == lowpower_pkg::ST_STOP) begin
            divCount <= 4'h0;
        end else if (divCount == lowpower_pkg::OSC_DIV_COUNT - 4'h1) begin
            divCount <= 4'h0;
        end else begin
            divCount <= divCount + 4'h1;
        end
    end
    assign divTick = (divCount == lowpower_pkg::OSC_DIV_COUNT - 4'h1);

    assign recoverTarget = shortStopRecovery ? lowpower_pkg::SHORT_RECOVERY
                                             : lowpower_pkg::LONG_RECOVERY;
    assign wakeEvent = anyIrq || breakRequest;
    assign lowpowerBreak = breakRequest
        && (state == lowpower_pkg::ST_WAIT || state == lowpower_pkg::ST_STOP);

    // sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            lowpower_pkg::ST_RUN: begin
                if (stopExec) begin
                    next_state = lowpower_pkg::ST_STOP;
                end else if (waitExec) begin
                    next_state = lowpower_pkg::ST_WAIT;
                end
            end
            lowpower_pkg::ST_WAIT: begin
                if (wakeEvent) begin
                    next_state = lowpower_pkg::ST_STACK;
                end
            end
            lowpower_pkg::ST_STOP: begin
                if (wakeEvent) begin
                    next_state = lowpower_pkg::ST_RECOVER;
                end
            end
            lowpower_pkg::ST_RECOVER: begin
                if (divTick && recoverCount == recoverTarget - 13'h1) begin
                    next_state = lowpower_pkg::ST_STACK;
                end
            end
            lowpower_pkg::ST_STACK: begin
                next_state = lowpower_pkg::ST_RUN;
            end
            default: begin
                next_state = lowpower_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (anyReset) begin
            state <= lowpower_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // recovery counter held clear until recovery starts
    always_ff @(posedge clk) begin
        if (anyReset || state != lowpower_pkg::ST_RECOVER) begin
            recoverCount <= 13'h0;
        end else if (divTick) begin
            recoverCount <= recoverCount + 13'h1;
        end
    end

    // clock enables
    always_ff @(posedge clk) begin
        if (anyReset) begin
            coreClockEnable <= 1'b1;
            peripheralClockEnable <= 1'b1;
            oscClockEnable <= 1'b1;
        end else begin
            coreClockEnable <= next_state == lowpower_pkg::ST_RUN
                || next_state == lowpower_pkg::ST_STACK;
            peripheralClockEnable <= next_state != lowpower_pkg::ST_STOP;
            oscClockEnable <= next_state != lowpower_pkg::ST_STOP;
        end
    end

    // stacking pulse, mask clear, watchdog
    always_ff @(posedge clk) begin
        if (anyReset) begin
            stackStart <= 1'b0;
            maskClear <= 1'b0;
            watchdogRun <= 1'b0;
        end else begin
            stackStart <= next_state == lowpower_pkg::ST_STACK;
            maskClear <= (waitExec || stopExec) && state == lowpower_pkg::ST_RUN;
            watchdogRun <= !watchdogDisable && next_state != lowpower_pkg::ST_STOP;
        end
    end

    // break state and trap vector
    always_ff @(posedge clk) begin
        if (anyReset) begin
            breakSeen <= 1'b0;
            forceVector <= 1'b0;
            vectorAddress <= 16'h0000;
        end else begin
            breakSeen <= breakRequest;
            forceVector <= breakRequest && !breakSeen;
            vectorAddress <= lowpower_pkg::TRAP_VECTOR;
        end
    end
    assign inBreak = breakSeen;

    // write channel capture, address and data in either order
    always_ff @(posedge clk) begin
        if (rst) begin
            haveAw <= 1'b0;
            haveW <= 1'b0;
            wrAddr <= 16'h0000;
            wrData <= 32'h0;
            wrStrb <= 4'h0;
        end else if (doWrite) begin
            haveAw <= 1'b0;
            haveW <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                haveAw <= 1'b1;
                wrAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                haveW <= 1'b1;
                wrData <= s_axi_wdata;
                wrStrb <= s_axi_wstrb;
            end
        end
    end
    assign doWrite = haveAw && haveW && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !haveAw && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !haveW && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // write response
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            if (hit(wrAddr, lowpower_pkg::BREAK_STATUS_OFFSET)
                || hit(wrAddr, lowpower_pkg::FLAG_CONTROL_OFFSET)
                || hit(wrAddr, lowpower_pkg::MODE_CONFIG_OFFSET)
                || hit(wrAddr, lowpower_pkg::PEND_HIGH_OFFSET)) begin
                s_axi_bresp <= 2'h0;
            end else begin
                s_axi_bresp <= 2'h2;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // break exit flag: set by break in low power, set wins over clear
    always_ff @(posedge clk) begin
        if (anyReset) begin
            breakExitedLowpower <= 1'b0;
        end else if (lowpowerBreak) begin
            breakExitedLowpower <= 1'b1;
        end else if (doWrite && wrStrb[0] && hit(wrAddr, lowpower_pkg::BREAK_STATUS_OFFSET)
                     && !wrData[lowpower_pkg::BREAK_EXITED_BIT]) begin
            breakExitedLowpower <= 1'b0;
        end
    end

    // software control bits
    always_ff @(posedge clk) begin
        if (anyReset) begin
            breakFlagClearEnable <= 1'b0;
            watchdogDisable <= lowpower_pkg::MODE_CONFIG_RESET[lowpower_pkg::WATCHDOG_DIS_BIT];
            shortStopRecovery <= lowpower_pkg::MODE_CONFIG_RESET[lowpower_pkg::SHORT_REC_BIT];
        end else if (doWrite && wrStrb[0]) begin
            if (hit(wrAddr, lowpower_pkg::FLAG_CONTROL_OFFSET)) begin
                breakFlagClearEnable <= wrData[lowpower_pkg::FLAG_CLEAR_EN_BIT];
            end else if (hit(wrAddr, lowpower_pkg::MODE_CONFIG_OFFSET)) begin
                watchdogDisable <= wrData[lowpower_pkg::WATCHDOG_DIS_BIT];
                shortStopRecovery <= wrData[lowpower_pkg::SHORT_REC_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (anyReset) begin
            breakExitedOut <= 1'b0;
        end else begin
            breakExitedOut <= breakExitedLowpower;
        end
    end

    // read channel, one beat answered the cycle after address taken
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            if (hit(s_axi_araddr, lowpower_pkg::PEND_HIGH_OFFSET)) begin
                s_axi_rdata <= {24'h0, pendingSourcesHigh};
            end else if (hit(s_axi_araddr, lowpower_pkg::BREAK_STATUS_OFFSET)) begin
                s_axi_rdata <= {30'h0, breakExitedLowpower, 1'b0};
            end else if (hit(s_axi_araddr, lowpower_pkg::FLAG_CONTROL_OFFSET)) begin
                s_axi_rdata <= {24'h0, breakFlagClearEnable, 7'h0};
            end else if (hit(s_axi_araddr, lowpower_pkg::MODE_CONFIG_OFFSET)) begin
                s_axi_rdata <= {30'h0, shortStopRecovery, watchdogDisable};
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // peripheral flag protection during break
    flag_guard guard (
        .clk(clk),
        .rst(anyReset),
        .inBreak(breakSeen),
        .clearEnable(breakFlagClearEnable),
        .flagSet(flagSet),
        .stepOne(clearStepOne),
        .stepTwo(clearStepTwo),
        .flags(protectedFlags)
    );
endmodule : lowpower_main
`default_nettype wire

// >>> verification/lowpower_props.sv
// assertions on the low-power sequencer ports
// assumes binding onto lowpower_main, one clock domain
`timescale 1ns/1ns
`default_nettype none
module lowpower_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic waitExec,
    input wire logic stopExec,
    input wire logic anyIrq,
    input wire logic breakRequest,
    input wire logic internalReset,
    input wire logic systemReset,
    input wire logic maskClear,
    input wire logic forceVector,
    input wire logic [15:0] vectorAddress,
    input wire logic inBreak,
    input wire logic coreClockEnable,
    input wire logic peripheralClockEnable,
    input wire logic oscClockEnable,
    input wire logic stackStart,
    input wire logic breakExitedOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic stopPending;
    // a stop not yet stacked, so recovery is not taken for wait
    always_ff @(posedge clk) begin
        if (rst || systemReset || stackStart) begin
            stopPending <= 1'b0;
        end else if (stopExec) begin
            stopPending <= 1'b1;
        end
    end
    a_mask_cleared:
    assert property ((waitExec || stopExec) |-> ##[1:2] maskClear) else $error("no mask clear");
    a_wait_gates_core:
    assert property (waitExec |-> ##[1:2] (!coreClockEnable && peripheralClockEnable))
        else $error("wait clocks wrong");
    a_irq_wakes_wait:
    assert property ((!stopPending && !coreClockEnable && peripheralClockEnable && anyIrq)
        |-> ##[1:3] stackStart)
        else $error("wait wake late");
    a_stop_clocks_off:
    assert property (stopExec |-> ##[1:2] !(oscClockEnable || coreClockEnable
        || peripheralClockEnable)) else $error("stop clocks on");
    a_stop_stays_off:
    assert property ((!oscClockEnable && !anyIrq && !breakRequest && !systemReset)
        |=> (!oscClockEnable || systemReset)) else $error("stop left early");
    a_stack_clocked:
    assert property (stackStart |-> (coreClockEnable && oscClockEnable))
        else $error("stack without clocks");
    a_break_vector:
    assert property ($rose(breakRequest)
        |-> ##[1:3] (forceVector && vectorAddress == lowpower_pkg::TRAP_VECTOR))
        else $error("break vector missing");
    a_reset_wins:
    assert property (internalReset |-> ##[0:2] systemReset) else $error("reset not taken");
    a_exit_flag_cause:
    assert property ($rose(breakExitedOut) |-> (inBreak || $past(inBreak)))
        else $error("exit flag without break");
endmodule : lowpower_props
bind lowpower_main lowpower_props chk (.clk, .rst, .waitExec, .stopExec, .anyIrq, .breakRequest,
    .internalReset, .systemReset, .maskClear, .forceVector, .vectorAddress, .inBreak,
    .coreClockEnable, .peripheralClockEnable, .oscClockEnable, .stackStart, .breakExitedOut);
`default_nettype wire

// >>> verification/core_model.sv
// processor core stand-in: raises an enabled interrupt and takes it at stacking
// assumes stackStart is a one-cycle pulse on clk
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic wakeReq,
    input wire logic stackStart,
    output logic anyIrq,
    output int latency
);
    // request holds until stacking acknowledges it
    always_ff @(posedge clk) begin
        if (rst) begin
            anyIrq <= 1'b0;
        end else if (wakeReq) begin
            anyIrq <= 1'b1;
            latency <= 0;
        end else if (stackStart) begin
            anyIrq <= 1'b0;
        end else if (anyIrq) begin
            latency <= latency + 1;
        end
    end
endmodule : core_model
`default_nettype wire

// >>> verification/test_lowpower_main.sv
// self-checking bench for the break and low-power sequencer
// assumes core_model and lowpower_props compiled alongside
`timescale 1ns/1ns
`default_nettype none
module test_lowpower_main;
    logic clk = 1'b0, rst = 1'b1, wakeReq = 1'b0, a, w;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, vectorAddress;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, systemReset, maskClear, forceVector, inBreak, coreClockEnable;
    logic peripheralClockEnable, oscClockEnable, watchdogRun, stackStart, breakExitedOut;
    logic waitExec = 0, stopExec = 0, anyIrq, breakRequest = 0, resetPin = 0, internalReset = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, br;
    logic [7:0] irqPending = 0, flagSet = 0, clearStepOne = 0, clearStepTwo = 0, protectedFlags;
    logic [33:0] expQ[$], maskQ[$];
    int latency, recCycles, miscompares = 0, check_count = 0, seed = 32'h92a8;
    lowpower_main dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .waitExec, .stopExec, .irqPending, .anyIrq, .breakRequest,
        .resetPin, .internalReset, .flagSet, .clearStepOne, .clearStepTwo, .systemReset,
        .maskClear, .forceVector, .vectorAddress, .inBreak, .coreClockEnable,
        .peripheralClockEnable, .oscClockEnable, .watchdogRun, .stackStart, .breakExitedOut,
        .protectedFlags);
    core_model core (.clk, .rst, .wakeReq, .stackStart, .anyIrq, .latency);
    always #2 clk = ~clk;
    task check(input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wrap_up;
        if (miscompares == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task axw(input logic [15:0] ad, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(negedge clk);
            a = s_axi_awready;
            w = s_axi_wready;
            @(posedge clk);
            if (a) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do begin
            @(negedge clk);
            a = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge clk);
        end while (!a);
        s_axi_bready <= 0;
        check(br, er);
    endtask : axw
    task axr(input logic [15:0] ad, input logic [33:0] e, input logic [33:0] m);
        expQ.push_back(e);
        maskQ.push_back(m);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(negedge clk);
            a = s_axi_arready;
            @(posedge clk);
        end while (!a);
        s_axi_arvalid <= 0;
        do begin
            @(negedge clk);
            a = s_axi_rvalid;
            @(posedge clk);
        end while (!a);
        s_axi_rready <= 0;
    endtask : axr
    task pulse(input logic wt, input logic st, input logic [7:0] fs, input logic [7:0] s1,
        input logic [7:0] s2);
        {waitExec, stopExec, flagSet, clearStepOne, clearStepTwo} <= {wt, st, fs, s1, s2};
        @(posedge clk);
        {waitExec, stopExec, flagSet, clearStepOne, clearStepTwo} <= 26'h0;
        repeat (4) @(posedge clk);
    endtask : pulse
    task wake;
        wakeReq <= 1;
        @(posedge clk);
        wakeReq <= 0;
        @(posedge clk);
        while (anyIrq) @(posedge clk);
    endtask : wake
    // read results leave the queue in order as they appear
    always @(negedge clk) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata} & maskQ[0], expQ[0]);
        if (s_axi_rvalid && s_axi_rready) void'(expQ.pop_front());
        if (s_axi_rvalid && s_axi_rready) void'(maskQ.pop_front());
    end
    // hang guard well past the longest expected run
    initial begin
        #300000;
        miscompares++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        // byte addresses are four times the register index
        axr(16'hf800, 34'h0, 34'h3_0000_0002);
        repeat (3) begin
            irqPending <= 8'($random(seed));
            @(posedge clk);
            axw(16'hf814, 32'h0000_00ff, 2'h0);
            axr(16'hf814, {26'h0, irqPending}, 34'h3_ffff_ffff);
        end
        axw(16'hfe10, 32'h1, 2'h2);
        axr(16'hfe10, 34'h2_0000_0000, 34'h3_ffff_ffff);
        pulse(1, 0, 8'h0, 8'h0, 8'h0);
        check({coreClockEnable, peripheralClockEnable, watchdogRun}, 3'b011);
        wake();
        check({latency <= 2, coreClockEnable}, 2'b11);
        pulse(0, 0, 8'h03, 8'h02, 8'h0);
        pulse(1, 0, 8'h0, 8'h0, 8'h0);
        breakRequest <= 1;
        // break is taken one edge later; step two must fall inside it
        @(posedge clk);
        pulse(0, 0, 8'h0, 8'h01, 8'h03);
        check({inBreak, breakExitedOut, vectorAddress, protectedFlags}, 26'h3_fffc03);
        axw(16'hf810, 32'h80, 2'h0);
        axr(16'hf810, 34'h80, 34'h3_0000_0080);
        pulse(0, 0, 8'h0, 8'h01, 8'h01);
        axw(16'hf810, 32'h0, 2'h0);
        breakRequest <= 0;
        pulse(0, 0, 8'h0, 8'h0, 8'h0);
        check(protectedFlags, 8'h02);
        pulse(0, 0, 8'h0, 8'h0, 8'h02);
        check(protectedFlags, 8'h00);
        axr(16'hf800, 34'h2, 34'h3_0000_0002);
        axw(16'hf800, 32'h0, 2'h0);
        axr(16'hf800, 34'h0, 34'h3_0000_0002);
        for (int i = 0; i < 2; i++) begin
            axw(16'hf820, {30'h0, i[0], 1'b0}, 2'h0);
            pulse(0, 1, 8'h0, 8'h0, 8'h0);
            check({oscClockEnable, coreClockEnable, peripheralClockEnable}, 3'h0);
            wake();
            // recovery ticks of the divided clock, plus the edge that leaves stop
            recCycles = int'(i ? lowpower_pkg::SHORT_RECOVERY : lowpower_pkg::LONG_RECOVERY);
            check(latency, recCycles * lowpower_pkg::OSC_DIV_COUNT + 1);
        end
        axw(16'hf820, 32'h1, 2'h0);
        pulse(1, 0, 8'h0, 8'h0, 8'h0);
        check(watchdogRun, 1'b0);
        wake();
        pulse(0, 1, 8'h0, 8'h0, 8'h0);
        breakRequest <= 1;
        repeat (4) @(posedge clk);
        check(breakExitedOut, 1'b1);
        breakRequest <= 0;
        internalReset <= 1;
        repeat (3) @(posedge clk);
        check(systemReset, 1'b1);
        internalReset <= 0;
        // reset pin passes the synchroniser before it takes effect
        resetPin <= 1;
        repeat (6) @(posedge clk);
        check(systemReset, 1'b1);
        resetPin <= 0;
        wrap_up();
    end
endmodule : test_lowpower_main
`default_nettype wire
